// *** adc_port_map.vh ***
// Constants for the converter result port: addresses, config layout, timing.
// Included by the result port and its conversion engine; definitions only.
`ifndef ADC_PORT_MAP_VH
`define ADC_PORT_MAP_VH
`define ADDR_LO_HI 7'h14
`define ADDR_LO_FL 7'h15
`define ADDR_FL_HI 7'h17
`define ADDR_FL_FL 7'h24
`define ADDR_HI_HI 7'h26
`define ADDR_HI_FL 7'h27
`define ADDR_GLOBAL 7'h77
`define CFG_WIDTH 6
`define CFG_RESET 6'h00
`define CFG_TEMP_BIT 5
`define CFG_REJ_A_BIT 4
`define CFG_REJ_B_BIT 3
`define CFG_GAIN_MSB 2
`define CFG_SPEED_BIT 0
`define RESULT_WIDTH 24
`define CONV_60_US 133000
`define CONV_50_US 160000
`define CONV_5060_US 147000
`define CLK_MHZ 50
`define EXTCLK_TIMEOUT 16'h2710
`endif

// *** conv_engine.v ***
// Conversion engine: times a conversion and forms the 24-bit result word.
// Assumes an upstream sample source supplies a signed 18-bit value at start.
`timescale 1ns/1ps
`include "adc_port_map.vh"
module conv_engine #(
  parameter T60 = `CONV_60_US * `CLK_MHZ,
  parameter T50 = `CONV_50_US * `CLK_MHZ,
  parameter T5060 = `CONV_5060_US * `CLK_MHZ
) (
  input wire clk,
  input wire sys_rst,
  input wire start,
  input wire [5:0] cfg,
  input wire signed [17:0] sample_a,
  input wire signed [17:0] sample_b,
  output reg busy_r,
  output reg [23:0] result_r
);
  reg [23:0] cnt_r;
  reg [5:0] cfg_r;
  reg signed [18:0] acc_r;
  wire temp = cfg_r[`CFG_TEMP_BIT];
  wire dbl = cfg_r[`CFG_SPEED_BIT] & ~temp;
  wire [1:0] rej = {cfg_r[`CFG_REJ_A_BIT], cfg_r[`CFG_REJ_B_BIT]};
  wire [23:0] full = (rej == 2'b01) ? T50[23:0] : (rej == 2'b10) ? T60[23:0] : T5060[23:0];
  wire [23:0] dur = dbl ? {1'b0, full[23:1]} : full;
  // Offset cancels by averaging two opposite-chopped samples unless double rate
  // Sum kept two bits wider and halved by slicing, so negative pairs keep their sign
  wire signed [19:0] pair_sum = {{2{sample_a[17]}}, sample_a} + {{2{sample_b[17]}}, sample_b};
  wire signed [18:0] avg = dbl ? {sample_a[17], sample_a} : pair_sum[19:1];
  function [23:0] encode;
    input signed [18:0] v;
    input [5:0] c;
    begin
      if (v > 19'sd65536)
        encode = {2'b11, 16'h0000, c};
      else if (v < -19'sd65537)
        encode = {2'b00, 16'hffff, c};
      else if (v == 19'sd65536)
        encode = {2'b11, 16'h0000, c};
      else if (v == -19'sd65537)
        encode = {2'b00, 16'hffff, c};
      else if (v >= 0)
        encode = {1'b1, v[16], v[15:0], c};
      else
        encode = {1'b0, 1'b1, v[15:0], c};
    end
  endfunction
  always @(posedge clk) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      cnt_r <= 24'h000000;
      cfg_r <= `CFG_RESET;
      acc_r <= 19'h00000;
      result_r <= 24'h800000;
    end else if (start) begin
      busy_r <= 1'b1;
      cfg_r <= cfg;
      cnt_r <= 24'h000000;
    end else if (busy_r) begin
      cnt_r <= cnt_r + 24'h000001;
      if (cnt_r == 24'h000000)
        acc_r <= avg;
      if (cnt_r >= dur) begin
        busy_r <= 1'b0;
        result_r <= encode(acc_r, cfg_r);
      end
    end
  end
endmodule

// *** adc_i2c_result_port.v ***
// I2C target port of the converter: address match, config write, result read.
// Assumes SCL/SDA and address pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`include "adc_port_map.vh"
module adc_i2c_result_port #(
  parameter T60 = `CONV_60_US * `CLK_MHZ,
  parameter T50 = `CONV_50_US * `CLK_MHZ,
  parameter T5060 = `CONV_5060_US * `CLK_MHZ,
  parameter EXT_TIMEOUT = `EXTCLK_TIMEOUT
) (
  input wire clk,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_oe,
  output reg sda_out,
  input wire addr_pin_high,
  input wire addr_pin_high_float,
  input wire addr_pin_low_clkin,
  input wire addr_pin_low_float,
  input wire signed [17:0] sample_a,
  input wire signed [17:0] sample_b,
  output reg busy,
  output reg [5:0] cfg_out,
  output reg [2:0] gain_code,
  output reg [1:0] reject_mode,
  output reg double_rate_select,
  output reg temp_input_select
);
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_AACK = 3'd2;
  localparam S_WR = 3'd3;
  localparam S_WACK = 3'd4;
  localparam S_RD = 3'd5;
  localparam S_RACK = 3'd6;

  reg [1:0] scl_s, sda_s, ph_s, pl_s, hf_s, lf_s;
  reg scl_d, sda_d;
  reg [2:0] st_r;
  reg [3:0] bit_r;
  reg [7:0] sh_r;
  reg [23:0] out_r;
  reg [4:0] rcnt_r;
  reg [5:0] cfg_r;
  reg valid_r;
  reg iophase_r;
  reg start_conv_r;
  reg [15:0] ext_cnt_r;
  reg ext_r;
  reg lf_d;
  wire conv_busy;
  wire [23:0] conv_result;

  wire scl = scl_s[1];
  wire sda = sda_s[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c = scl & scl_d & sda_d & ~sda;
  wire stop_c = scl & scl_d & ~sda_d & sda;

  // Pin code: 0 low, 1 float, 2 high
  function [6:0] decode_addr;
    input [1:0] hi_pin;
    input [1:0] lo_pin;
    begin
      case ({hi_pin, lo_pin})
        4'b0010: decode_addr = `ADDR_LO_HI;
        4'b0001: decode_addr = `ADDR_LO_FL;
        4'b0110: decode_addr = `ADDR_FL_HI;
        4'b0101: decode_addr = `ADDR_FL_FL;
        4'b1010: decode_addr = `ADDR_HI_HI;
        4'b1001: decode_addr = `ADDR_HI_FL;
        default: decode_addr = 7'h7f;
      endcase
    end
  endfunction

  wire [1:0] hi_code = hf_s[1] ? 2'd1 : (ph_s[1] ? 2'd2 : 2'd0);
  wire [1:0] lo_code = ext_r ? 2'd2 : (lf_s[1] ? 2'd1 : (pl_s[1] ? 2'd2 : 2'd0));
  wire [6:0] my_addr = decode_addr(hi_code, lo_code);
  wire addr_hit = (sh_r[7:1] == my_addr) || (sh_r[7:1] == `ADDR_GLOBAL);
  // Read refused after a full read in the same phase until a conversion refills
  wire can_ack = ~conv_busy & ~(sh_r[0] & ~valid_r);

  conv_engine #(
    .T60(T60),
    .T50(T50),
    .T5060(T5060)
  ) u_conv (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(start_conv_r),
    .cfg(cfg_r),
    .sample_a(sample_a),
    .sample_b(sample_b),
    .busy_r(conv_busy),
    .result_r(conv_result)
  );

  always @(posedge clk) begin
    if (sys_rst) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      ph_s <= 2'b00;
      pl_s <= 2'b00;
      hf_s <= 2'b00;
      lf_s <= 2'b00;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      lf_d <= 1'b0;
    end else begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      ph_s <= {ph_s[0], addr_pin_high};
      pl_s <= {pl_s[0], addr_pin_low_clkin};
      hf_s <= {hf_s[0], addr_pin_high_float};
      lf_s <= {lf_s[0], addr_pin_low_float};
      scl_d <= scl;
      sda_d <= sda;
      lf_d <= pl_s[1];
    end
  end

  // External clock seen if the low pin keeps toggling within the timeout
  always @(posedge clk) begin
    if (sys_rst) begin
      ext_cnt_r <= 16'h0000;
      ext_r <= 1'b0;
    end else if (pl_s[1] != lf_d) begin
      ext_cnt_r <= 16'h0000;
      ext_r <= 1'b1;
    end else if (ext_cnt_r == EXT_TIMEOUT[15:0]) begin
      ext_r <= 1'b0;
    end else begin
      ext_cnt_r <= ext_cnt_r + 16'h0001;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      st_r <= S_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      out_r <= 24'h000000;
      rcnt_r <= 5'h00;
      cfg_r <= `CFG_RESET;
      valid_r <= 1'b0;
      iophase_r <= 1'b0;
      start_conv_r <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      busy <= 1'b0;
      cfg_out <= `CFG_RESET;
      gain_code <= 3'h0;
      reject_mode <= 2'h0;
      double_rate_select <= 1'b0;
      temp_input_select <= 1'b0;
    end else begin
      start_conv_r <= 1'b0;
      busy <= conv_busy;
      cfg_out <= cfg_r;
      gain_code <= cfg_r[`CFG_TEMP_BIT] ? 3'h0 : cfg_r[`CFG_GAIN_MSB:`CFG_GAIN_MSB-2];
      reject_mode <= {cfg_r[`CFG_REJ_A_BIT], cfg_r[`CFG_REJ_B_BIT]};
      double_rate_select <= cfg_r[`CFG_SPEED_BIT] & ~cfg_r[`CFG_TEMP_BIT];
      temp_input_select <= cfg_r[`CFG_TEMP_BIT];
      // Result latched when conversion finishes; held until the next conversion finishes
      if (busy & ~conv_busy) begin
        valid_r <= 1'b1;
        out_r <= conv_result;
      end
      if (stop_c) begin
        sda_oe <= 1'b0;
        st_r <= S_IDLE;
        if (iophase_r) begin
          iophase_r <= 1'b0;
          start_conv_r <= ~conv_busy;
          valid_r <= 1'b0;
        end
      end else if (start_c) begin
        sda_oe <= 1'b0;
        st_r <= S_ADDR;
        bit_r <= 4'h0;
      end else begin
        case (st_r)
          S_ADDR: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda};
              bit_r <= bit_r + 4'h1;
            end
            if (scl_fall && bit_r == 4'h8) begin
              if (addr_hit && can_ack) begin
                sda_oe <= 1'b1;
                iophase_r <= 1'b1;
                st_r <= S_AACK;
              end else begin
                st_r <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              bit_r <= 4'h0;
              rcnt_r <= 5'h00;
              if (sh_r[0]) begin
                st_r <= S_RD;
                sda_oe <= ~out_r[23];
              end else begin
                st_r <= S_WR;
                sda_oe <= 1'b0;
              end
            end
          end
          S_WR: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda};
              bit_r <= bit_r + 4'h1;
            end
            if (scl_fall && bit_r == 4'h8) begin
              cfg_r <= sh_r[7:2];
              sda_oe <= 1'b1;
              st_r <= S_WACK;
            end
          end
          S_WACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              bit_r <= 4'h0;
              st_r <= S_WR;
            end
          end
          S_RD: begin
            if (scl_fall) begin
              bit_r <= bit_r + 4'h1;
              rcnt_r <= rcnt_r + 5'h01;
              if (bit_r == 4'h7) begin
                sda_oe <= 1'b0;
                st_r <= S_RACK;
              end else begin
                sda_oe <= ~out_r[5'd22 - rcnt_r];
              end
              if (rcnt_r == 5'd23) begin
                valid_r <= 1'b0;
                iophase_r <= 1'b0;
                start_conv_r <= 1'b1;
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              sh_r[1] <= sda;
            end
            if (scl_fall) begin
              bit_r <= 4'h0;
              if (sh_r[1] || rcnt_r == 5'd24) begin
                st_r <= S_IDLE;
              end else begin
                st_r <= S_RD;
                sda_oe <= ~out_r[5'd23 - rcnt_r];
              end
            end
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// *** adc_i2c_result_port_sva.sv ***
// Checker for the converter result port, bound to its top ports.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps
module adc_port_sva #(
  parameter T50 = 1,
  parameter T5060 = 1
) (
  input wire clk,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_oe,
  input wire sda_out,
  input wire busy,
  input wire [5:0] cfg_out,
  input wire [2:0] gain_code,
  input wire [1:0] reject_mode,
  input wire double_rate_select,
  input wire temp_input_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  integer cnt_r;
  always @(posedge clk) cnt_r <= (sys_rst || !busy) ? 0 : cnt_r + 1;
  a_pin_open_drain: assert property (sda_out == 1'b0) else $error("sda_out not low");
  a_rst_clean: assert property ($fell(sys_rst) |-> !sda_oe && !busy && cfg_out == 6'h00)
    else $error("bad state after reset");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved, scl high");
  a_oe_steady: assert property (scl_in && $past(scl_in, 4) |-> $stable(sda_oe))
    else $error("sda not steady");
  a_busy_quiet: assert property (busy && $past(busy, 8) |-> !sda_oe) else $error("drive while busy");
  a_cfg_hold: assert property (busy && $past(busy) |-> $stable(cfg_out)) else $error("cfg changed");
  a_conv_min: assert property ($fell(busy) && cfg_out == 6'h00 |-> $past(cnt_r) + 8 >= T5060)
    else $error("conversion too short");
  a_conv_max: assert property (cnt_r <= 2 * T50 + 16) else $error("conversion too long");
  a_cfg_decode: assert property (cfg_out == 6'h00 && $past(cfg_out) == 6'h00 |-> gain_code == 3'h0
    && reject_mode == 2'h0 && !double_rate_select && !temp_input_select) else $error("bad decode");
  c_conv: cover property ($rose(busy));
  c_ack: cover property ($rose(sda_oe));
  c_done: cover property ($fell(busy));
endmodule
bind adc_i2c_result_port adc_port_sva #(.T50(T50), .T5060(T5060)) i_sva (.clk(clk), .sys_rst(sys_rst),
  .scl_in(scl_in), .sda_oe(sda_oe), .sda_out(sda_out), .busy(busy), .cfg_out(cfg_out),
  .gain_code(gain_code), .reject_mode(reject_mode), .double_rate_select(double_rate_select),
  .temp_input_select(temp_input_select));

// *** i2c_host_model.sv ***
// Behavioural I2C controller for the result port bench.
// Assumes SDA is wired-and with a pull-up; reports acks and read words.
`timescale 1ns/1ps
module i2c_host_model (
  input wire clk,
  input wire sda_w,
  output reg scl,
  output reg sda_h,
  output reg obs_stb,
  output reg [23:0] obs_val
);
  reg idle = 1'b1;
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
    obs_stb = 1'b0;
    obs_val = 24'h000000;
  end
  task hc(input s, input d, input integer n);
    begin
      @(posedge clk);
      scl <= s;
      sda_h <= d;
      repeat (n - 1) @(posedge clk);
    end
  endtask
  task rep(input [23:0] v);
    begin
      @(posedge clk);
      obs_val <= v;
      obs_stb <= 1'b1;
      @(posedge clk);
      obs_stb <= 1'b0;
    end
  endtask
  // SCL falls first so SDA never moves under a high clock
  task bitx(input d, output q);
    begin
      hc(1'b0, sda_h, 2);
      hc(1'b0, d, 4);
      hc(1'b1, d, 6);
      q = sda_w;
    end
  endtask
  task start;
    begin
      if (!idle) begin
        hc(1'b0, sda_h, 2);
        hc(1'b0, 1'b1, 4);
      end
      hc(1'b1, 1'b1, 4);
      hc(1'b1, 1'b0, 4);
      hc(1'b0, 1'b0, 4);
      idle = 1'b0;
    end
  endtask
  // Only issued after a ninth clock, never inside a byte
  task stop;
    begin
      hc(1'b0, sda_h, 2);
      hc(1'b0, 1'b0, 4);
      hc(1'b1, 1'b0, 4);
      hc(1'b1, 1'b1, 6);
      idle = 1'b1;
    end
  endtask
  task send(input [7:0] b);
    integer i;
    reg q;
    begin
      for (i = 7; i >= 0; i = i - 1) bitx(b[i], q);
      bitx(1'b1, q);
      rep({23'h000000, q});
    end
  endtask
  task read3;
    integer i;
    reg q;
    reg [23:0] w;
    begin
      for (i = 0; i < 24; i = i + 1) begin
        bitx(1'b1, q);
        w = {w[22:0], q};
        if (i % 8 == 7) bitx(i == 23, q);
      end
      rep(w);
    end
  endtask
endmodule

// *** adc_i2c_result_port_tb.sv ***
// Self-checking bench for the result port with a behavioural controller.
// Assumes 50 MHz clk and a 160 ns conversion clock on the second pin.
`timescale 1ns/1ps
module adc_i2c_result_port_tb;
  localparam [23:0] PINS = {4'h2, 4'h1, 4'h6, 4'h5, 4'ha, 4'h9};
  localparam [41:0] ADDRS = {7'h14, 7'h15, 7'h17, 7'h24, 7'h26, 7'h27};
  localparam [179:0] VALS = {18'h00000, 18'h3ffff, 18'h0ffff, 18'h30000, 18'h08000,
    18'h37fff, 18'h10000, 18'h2ffff, 18'h11170, 18'h2ee90};
  reg clk = 1'b0, sys_rst = 1'b1, ext_on = 1'b0, ext_clk = 1'b0;
  reg p_hi = 1'b0, p_hif = 1'b0, p_lo = 1'b1, p_lof = 1'b0;
  reg signed [17:0] smp = 18'h00000;
  reg [31:0] rnd = 32'h1e37;
  integer fail_count = 0, num_checks = 0, i, n;
  reg [23:0] exp_q [$];
  wire scl, sda_h, sda_oe, busy, stb;
  wire [23:0] obs;
  wire sda_w = sda_h & ~sda_oe;
  adc_i2c_result_port #(.T60(200), .T50(240), .T5060(220), .EXT_TIMEOUT(50)) i_dut (.clk(clk),
    .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_w), .sda_oe(sda_oe), .sda_out(), .addr_pin_high(p_hi),
    .addr_pin_high_float(p_hif), .addr_pin_low_clkin(ext_on ? ext_clk : p_lo), .addr_pin_low_float(p_lof),
    .sample_a(smp), .sample_b(smp), .busy(busy), .cfg_out(), .gain_code(), .reject_mode(),
    .double_rate_select(), .temp_input_select());
  i2c_host_model i_host (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_h(sda_h), .obs_stb(stb), .obs_val(obs));
  initial forever #10 clk = ~clk;
  initial begin
    #7;
    forever #80 ext_clk = ~ext_clk;
  end
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [23:0] enc(input signed [17:0] v);
    begin
      if (v >= 18'sh10000) enc = {2'b11, 16'h0000, 6'h00};
      else if (v < -18'sh10000) enc = {2'b00, 16'hffff, 6'h00};
      else enc = {~v[17], v[16:0], 6'h00};
    end
  endfunction
  task check(input [23:0] seen, input [23:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask
  always @(posedge clk) if (stb) check(obs, exp_q.pop_front());
  task results;
    begin
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task wait_idle;
    begin
      n = 0;
      repeat (4) @(posedge clk);
      while (busy !== 1'b0 && n < 2000) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n >= 2000) begin
        fail_count = fail_count + 1;
        $display("Error at %0t: busy stuck", $time);
        results;
      end
    end
  endtask
  task wr(input [6:0] a, input [23:0] e);
    begin
      exp_q.push_back(e);
      i_host.start;
      i_host.send({a, 1'b0});
      i_host.stop;
    end
  endtask
  task rd(input [6:0] a, input [23:0] e, input [23:0] w);
    begin
      exp_q.push_back(e);
      i_host.start;
      i_host.send({a, 1'b1});
      if (e == 24'h000000) begin
        exp_q.push_back(w);
        i_host.read3;
      end
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    check({23'h000000, busy}, 24'h000000);
    rd(7'h14, 24'h000001, 24'h000000);
    i_host.stop;
    $display("Test reset done");
    for (i = 0; i < 6; i = i + 1) begin
      {p_hi, p_hif, p_lo, p_lof} <= PINS[23 - 4 * i -: 4];
      // A pin step looks like one clock edge; let the clock detector time out first
      repeat (80) @(posedge clk);
      wr(ADDRS[41 - 7 * i -: 7] ^ 7'h40, 24'h000001);
      wr(ADDRS[41 - 7 * i -: 7], 24'h000000);
      wait_idle;
    end
    wr(7'h77, 24'h000000);
    rd(7'h27, 24'h000001, 24'h000000);
    i_host.stop;
    wait_idle;
    $display("Test address done");
    for (i = 0; i < 13; i = i + 1) begin
      rnd = xs(rnd);
      smp <= (i < 10) ? VALS[179 - 18 * i -: 18] : rnd[17:0];
      wr(7'h27, 24'h000000);
      wait_idle;
      rd(7'h27, 24'h000000, enc(smp));
      rd(7'h27, 24'h000001, 24'h000000);
      i_host.stop;
      wait_idle;
    end
    $display("Test result codes done");
    {p_hi, p_hif, p_lof} <= 3'h0;
    ext_on <= 1'b1;
    repeat (200) @(posedge clk);
    wr(7'h14, 24'h000000);
    wait_idle;
    ext_on <= 1'b0;
    p_lo <= 1'b0;
    repeat (200) @(posedge clk);
    wr(7'h14, 24'h000001);
    wait_idle;
    $display("Test clock pin done");
    results;
  end
endmodule
